// ---- dv/uhlp_regs_bench.sv ----
// self-checking bench of the list pointer bank
module uhlp_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import uhlp_pkg::*;
    logic i_clock = 0, i_sys_rst = 1;
    uhlp_reg_req_s  i_req = '0;
    uhlp_bulk_evt_s i_bulk_evt = '0;
    uhlp_done_evt_s i_done_evt = '0;
    logic [31:0] i_control = '0, i_cmd_status = '0, o_rdata, o_td_link_value;
    logic [31:0] o_shared_comm_area_value, fi_w;
    logic o_list_filled_clear, o_td_link_valid, o_shared_comm_area_valid;
    logic [27:0] o_bulk_current_addr, m_bulk, a;
    logic [27:0] q[$];
    logic [13:0] o_frame_interval_bits;
    logic [14:0] o_packet_counter_load;
    int num_errors = 0, n_checks = 0;
    always #2 i_clock = ~i_clock;
    uhlp_regs uhlp_regs_i (.*);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task st(uhlp_reg_req_s r, uhlp_bulk_evt_s b, uhlp_done_evt_s d);
        @(negedge i_clock);
        i_req = r;
        i_bulk_evt = b;
        i_done_evt = d;
    endtask : st
    task idle;
        st('0, '0, '0);
    endtask : idle
    task wr(input logic [7:0] ad, input logic [31:0] v);
        st('{1'b0, 1'b1, ad, v}, '0, '0);
        idle();
    endtask : wr
    task rd(input logic [7:0] ad, input logic [31:0] e);
        st('{1'b1, 1'b0, ad, 32'h0}, '0, '0);
        idle();
        chk(o_rdata, e);
    endtask : rd
    task results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        #40000;
        num_errors++;
        results();
    end
    initial begin
        a = 28'($urandom(32'h353f8a40));
        repeat (5) @(posedge i_clock);
        @(negedge i_clock) i_sys_rst = 0;
        rd(OFS_BULK_CURRENT, 32'h0);
        rd(OFS_DONE_HEAD, 32'h0);
        rd(OFS_FRAME_INTV, 32'h0000_2edf);
        m_bulk = 28'($urandom);
        wr(OFS_BULK_CURRENT, {m_bulk, 4'h0});
        rd(OFS_BULK_CURRENT, {m_bulk, 4'h0});
        i_control[BLE_BIT] = 1'b1;
        wr(OFS_BULK_CURRENT, 32'hffff_fff0);
        rd(OFS_BULK_CURRENT, {m_bulk, 4'h0});
        repeat (3) begin
            m_bulk = 28'($urandom) | 28'h1;
            st('0, '{1'b1, 1'b0, 1'b0, m_bulk}, '0);
            idle();
            rd(OFS_BULK_CURRENT, {m_bulk, 4'h0});
            chk(32'(o_bulk_current_addr), 32'(m_bulk));
        end
        a = 28'($urandom) | 28'h1;
        wr(OFS_BULK_HEAD, {a, 4'h0});
        st('0, '{1'b0, 1'b1, 1'b0, 28'h0}, '0);
        idle();
        chk(32'(o_list_filled_clear), 32'h0);
        rd(OFS_BULK_CURRENT, {m_bulk, 4'h0});
        i_cmd_status[CLF_BIT] = 1'b1;
        st('0, '{1'b0, 1'b1, 1'b0, 28'h0}, '0);
        idle();
        chk(32'(o_list_filled_clear), 32'h1);
        i_cmd_status = '0;
        st('0, '{1'b0, 1'b0, 1'b1, 28'h0}, '0);
        rd(OFS_BULK_CURRENT, {a, 4'h0});
        q.push_back(28'h0);
        repeat (3) begin
            a = 28'($urandom);
            st('0, '0, '{1'b1, a, 1'b0});
            if (q.size() > 1) chk(o_td_link_value, {q[$-1], 4'h0});
            q.push_back(a);
        end
        st('0, '0, '{1'b0, 28'h0, 1'b1});
        chk(o_td_link_value, {q[$-1], 4'h0});
        idle();
        chk(o_shared_comm_area_value, {q[$], 4'h0});
        rd(OFS_DONE_HEAD, 32'h0);
        a = 28'($urandom);
        st('0, '0, '{1'b1, a, 1'b0});
        idle();
        rd(OFS_DONE_HEAD, {a, 4'h0});
        st('0, '0, '{1'b0, 28'h0, 1'b1});
        st('0, '0, '{1'b0, 28'h0, 1'b1});
        idle();
        chk(o_shared_comm_area_value, 32'h0);
        fi_w = $urandom & 32'h7fff_3fff;
        wr(OFS_FRAME_INTV, fi_w);
        chk(32'(o_frame_interval_bits), 32'h2edf);
        st('0, '{1'b0, 1'b0, 1'b1, 28'h0}, '0);
        idle();
        chk(32'(o_frame_interval_bits), {18'h0, fi_w[13:0]});
        chk(32'(o_packet_counter_load), {17'h0, fi_w[30:16]});
        rd(OFS_FRAME_INTV, fi_w);
        results();
    end
endmodule : uhlp_regs_bench
bind uhlp_regs uhlp_regs_props uhlp_regs_props_i (.*);

// ---- dv/uhlp_regs_props.sv ----
// checker of the list pointer bank ports
module uhlp_regs_props (
    input wire logic                     i_clock,
    input wire logic                     i_sys_rst,
    input wire uhlp_pkg::uhlp_reg_req_s  i_req,
    input wire logic [31:0]              i_cmd_status,
    input wire uhlp_pkg::uhlp_bulk_evt_s i_bulk_evt,
    input wire uhlp_pkg::uhlp_done_evt_s i_done_evt,
    input wire logic [31:0]              o_rdata,
    input wire logic                     o_list_filled_clear,
    input wire logic [31:0]              o_td_link_value,
    input wire logic                     o_td_link_valid,
    input wire logic [31:0]              o_shared_comm_area_value,
    input wire logic                     o_shared_comm_area_valid,
    input wire logic [13:0]              o_frame_interval_bits
);
    import uhlp_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    sequence s_done;
        i_done_evt.done && !i_done_evt.flush;
    endsequence
    sequence s_flush;
        i_done_evt.flush;
    endsequence
    link_pulse_a: assert property (s_done |=> o_td_link_valid)
        else $error("no link pulse");
    link_chain_a: assert property (s_done ##1 s_done |=>
        o_td_link_value == {$past(i_done_evt.td_addr, 2), 4'h0})
        else $error("bad link value");
    head_flush_a: assert property (s_done ##1 s_flush |=>
        o_shared_comm_area_value == {$past(i_done_evt.td_addr, 2), 4'h0})
        else $error("bad shared value");
    flush_pulse_a: assert property (s_flush |=> o_shared_comm_area_valid)
        else $error("no shared pulse");
    head_clear_a: assert property (s_flush ##1 s_flush |=>
        o_shared_comm_area_value == 32'h0) else $error("head not cleared");
    fill_clear_a: assert property (i_bulk_evt.at_end &&
        i_cmd_status[CLF_BIT] |=> o_list_filled_clear)
        else $error("no flag clear");
    fill_keep_a: assert property (!i_cmd_status[CLF_BIT] |=>
        !o_list_filled_clear) else $error("stray flag clear");
    fi_hold_a: assert property (!i_bulk_evt.sof |=>
        $stable(o_frame_interval_bits)) else $error("interval off sof");
    rsvd_read_a: assert property (i_req.read &&
        i_req.addr != OFS_FRAME_INTV |=> o_rdata[3:0] == 4'h0)
        else $error("reserved bits set");
endmodule : uhlp_regs_props

// ---- hdl/uhlp_pkg.sv ----
// package of register map, field layout and carriers for the list pointer bank
package uhlp_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_BULK_HEAD    = 8'h28;
    localparam logic [7:0]  OFS_BULK_CURRENT = 8'h2c;
    localparam logic [7:0]  OFS_DONE_HEAD    = 8'h30;
    localparam logic [7:0]  OFS_FRAME_INTV   = 8'h34;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int          PTR_LSB          = 4;
    localparam int          PTR_W            = 28;
    localparam logic [3:0]  PTR_RSVD         = 4'h0;
    localparam logic [31:0] PTR_RESET        = 32'h0000_0000;
    localparam int          FI_LSB           = 0;
    localparam int          FI_W             = 14;
    localparam int          LP_LSB           = 16;
    localparam int          LP_W             = 15;
    localparam int          TOG_BIT          = 31;
    localparam logic [13:0] FI_NOMINAL       = 14'h2edf;
    localparam logic [14:0] LP_RESET         = 15'h0000;
    localparam int          CLF_BIT          = 1;
    localparam int          BLE_BIT          = 5;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } uhlp_reg_req_s;

    typedef struct packed {
        logic             served;
        logic             at_end;
        logic             sof;
        logic [PTR_W-1:0] next_ptr;
    } uhlp_bulk_evt_s;

    typedef struct packed {
        logic             done;
        logic [PTR_W-1:0] td_addr;
        logic             flush;
    } uhlp_done_evt_s;

endpackage : uhlp_pkg

// ---- hdl/uhlp_regs.sv ----
// bulk current pointer, done queue head and frame interval registers
module uhlp_regs (
    input  wire logic                    i_clock,
    input  wire logic                    i_sys_rst,
    input  wire uhlp_pkg::uhlp_reg_req_s i_req,
    output logic [31:0]                  o_rdata,
    input  wire logic [31:0]             i_control,
    input  wire logic [31:0]             i_cmd_status,
    output logic                         o_list_filled_clear,
    input  wire uhlp_pkg::uhlp_bulk_evt_s i_bulk_evt,
    output logic [uhlp_pkg::PTR_W-1:0]   o_bulk_current_addr,
    input  wire uhlp_pkg::uhlp_done_evt_s i_done_evt,
    output logic [31:0]                  o_td_link_value,
    output logic                         o_td_link_valid,
    output logic [31:0]                  o_shared_comm_area_value,
    output logic                         o_shared_comm_area_valid,
    output logic [uhlp_pkg::FI_W-1:0]    o_frame_interval_bits,
    output logic [uhlp_pkg::LP_W-1:0]    o_packet_counter_load
);
    import uhlp_pkg::*;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input uhlp_reg_req_s r,
                                 input logic [7:0] ofs);
        hit = r.addr == ofs;
    endfunction : hit

    function automatic logic [31:0] ptr_word(input logic [PTR_W-1:0] p);
        ptr_word = {p, PTR_RSVD};
    endfunction : ptr_word

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [PTR_W-1:0] bulk_current_addr;
    logic [PTR_W-1:0] bulk_list_head;
    logic [PTR_W-1:0] completed_descriptor_addr;
    logic [FI_W-1:0]  frame_interval_bits;
    logic [LP_W-1:0]  largest_packet_bits;
    logic             interval_toggle;
    logic             bulk_list_enable;
    logic             list_filled_flag;
    logic             bulk_list_end;
    logic             bulk_reload;
    logic             bulk_sw_write;
    logic             head_sw_write;
    logic [31:0]      next_rdata;

    // ------------------------------------------------------------------
    // control inputs and event decode
    // ------------------------------------------------------------------
    assign bulk_list_enable = i_control[BLE_BIT];
    assign list_filled_flag = i_cmd_status[CLF_BIT];
    // a served descriptor whose link is zero closes the list
    assign bulk_list_end    = i_bulk_evt.at_end ||
                              (i_bulk_evt.served &&
                               i_bulk_evt.next_ptr == '0);
    assign bulk_reload      = bulk_list_end && list_filled_flag;
    // current pointer writes land only while the list engine is stopped
    assign bulk_sw_write    = i_req.write &&
                              hit(i_req, OFS_BULK_CURRENT) &&
                              !bulk_list_enable;
    assign head_sw_write    = i_req.write && hit(i_req, OFS_BULK_HEAD);

    // ------------------------------------------------------------------
    // bulk head copy
    // ------------------------------------------------------------------
    // head pointer mirrors the value written at its own offset
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            bulk_list_head <= PTR_RESET[31:PTR_LSB];
        end else if (head_sw_write) begin
            bulk_list_head <= i_req.wdata[31:PTR_LSB];
        end
    end

    // ------------------------------------------------------------------
    // bulk current pointer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            bulk_current_addr <= PTR_RESET[31:PTR_LSB];
        end else if (bulk_reload) begin
            bulk_current_addr <= bulk_list_head;
        end else if (i_bulk_evt.served) begin
            bulk_current_addr <= i_bulk_evt.next_ptr;
        end else if (bulk_sw_write) begin
            bulk_current_addr <= i_req.wdata[31:PTR_LSB];
        end
        // at_end with the flag clear leaves the pointer alone; a served zero link loads zero while the flag is clear
        // no reload at sof: pointer simply persists
    end

    // clear request to the command status register, one cycle wide
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_list_filled_clear <= 1'b0;
        end else begin
            o_list_filled_clear <= bulk_reload;
        end
    end

    // ------------------------------------------------------------------
    // done queue head
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        o_td_link_valid          <= 1'b0;
        o_shared_comm_area_valid <= 1'b0;
        if (i_sys_rst) begin
            completed_descriptor_addr <= PTR_RESET[31:PTR_LSB];
            o_td_link_value           <= '0;
            o_shared_comm_area_value  <= '0;
        // flush wins over a completion in the same cycle
        end else if (i_done_evt.flush) begin
            o_shared_comm_area_value  <= ptr_word(completed_descriptor_addr);
            o_shared_comm_area_valid  <= 1'b1;
            completed_descriptor_addr <= '0;
        end else if (i_done_evt.done) begin
            o_td_link_value           <= ptr_word(completed_descriptor_addr);
            o_td_link_valid           <= 1'b1;
            completed_descriptor_addr <= i_done_evt.td_addr;
        end else if (i_req.write && hit(i_req, OFS_DONE_HEAD)) begin
            completed_descriptor_addr <= i_req.wdata[31:PTR_LSB];
        end
    end

    // ------------------------------------------------------------------
    // frame interval
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            frame_interval_bits <= FI_NOMINAL;
            largest_packet_bits <= LP_RESET;
            interval_toggle     <= 1'b0;
        end else if (i_req.write && hit(i_req, OFS_FRAME_INTV)) begin
            frame_interval_bits <= i_req.wdata[FI_LSB +: FI_W];
            largest_packet_bits <= i_req.wdata[LP_LSB +: LP_W];
            interval_toggle     <= i_req.wdata[TOG_BIT];
        end
    end

    // ------------------------------------------------------------------
    // frame values applied at sof
    // ------------------------------------------------------------------
    // written fields wait for the next sof before they take effect
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_frame_interval_bits <= FI_NOMINAL;
            o_packet_counter_load <= LP_RESET;
        end else if (i_bulk_evt.sof) begin
            o_frame_interval_bits <= frame_interval_bits;
            o_packet_counter_load <= largest_packet_bits;
        end
    end

    // ------------------------------------------------------------------
    // bulk pointer output copy
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_bulk_current_addr <= '0;
        end else begin
            o_bulk_current_addr <= bulk_current_addr;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // unmapped offsets and idle cycles read as zero
    always_comb begin
        next_rdata = '0;
        if (i_req.read) begin
            if (hit(i_req, OFS_BULK_CURRENT)) begin
                next_rdata = ptr_word(bulk_current_addr);
            end else if (hit(i_req, OFS_DONE_HEAD)) begin
                next_rdata = ptr_word(completed_descriptor_addr);
            end else if (hit(i_req, OFS_FRAME_INTV)) begin
                next_rdata = {interval_toggle, largest_packet_bits, 2'h0,
                              frame_interval_bits};
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= next_rdata;
        end
    end

endmodule : uhlp_regs
